// *** ebr_bus_ctrl.sv ***
// External bus controller: ready combining, wait states, posted writes,
// bank compare, data bus keeper and page selects.
// Assumes mclk_i is the internal phase clock; pins arrive asynchronously.
//
// Summary of operation
// RL1: Combined ready sampled every phase clock rising edge
// RL2: Selector bits 4:3 pick ready source
// RL3: Reset selector ORs counter with ready
// RL4: AND mode: ready low completes immediately
// RL5: OR mode, ready low: count and bank
// RL6: OR mode, ready high: extend beyond count
// RL7: Bank change before read inserts one idle
// RL8: Writes posted; buffer holds address and data
// RL9: Keeper holds data unless float control low
// RL10: External logic may feed address into ready
// RL11: Four page selects decoded from top bits
// RL12: One bus control register sets timing
// RL13: Counter loads count, ready after count cycles
// RL14: External ready input is active low
//
// The plain strobed port and the address map are this design's own decisions.
`include "ebr_cfg.svh"

module ebr_bus_ctrl (
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [`EBR_REG_AW-1:0] reg_addr_i,
  input wire logic [`EBR_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [`EBR_DW-1:0] reg_rdata_o,
  // Core access request
  input wire logic req_valid_i,
  input wire logic req_we_i,
  input wire logic [`EBR_AW-1:0] req_addr_i,
  input wire logic [`EBR_DW-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic [`EBR_DW-1:0] rd_data_o,
  output logic rd_valid_o,
  // External pins
  output logic [`EBR_AW-1:0] ext_addr_o,
  output logic [`EBR_DW-1:0] ext_data_o,
  output logic ext_data_oe_n_o,
  input wire logic [`EBR_DW-1:0] ext_data_i,
  output logic ext_external_access_strobe_n_o,
  output logic ext_rw_o,
  input wire logic ext_ready_n_i,
  input wire logic pin_float_control_n_i,
  output logic [`EBR_NPAGE-1:0] page_sel_n_o,
  // Bus keeper drive
  output logic [`EBR_DW-1:0] keep_val_o,
  output logic keep_en_o
);
  import ebr_pkg::*;

  ebr_ctrl_state_t s_reg;
  ebr_ctrl_state_t s_next;

  logic int_ready;
  logic cnt_load;
  logic ext_ready;
  logic comb_ready;
  logic floating;
  logic start;
  logic bank_change;
  logic [`EBR_BANK_HI-`EBR_BANK_LO:0] req_bank;
  logic [`EBR_DW-1:0] busctl_view;
  logic [`EBR_DW-1:0] status_view;

  ebr_wait_counter u_wait (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(cnt_load),
    .load_val_i(s_reg.wcnt),
    .int_ready_o(int_ready)
  );

  ebr_page_decode u_page (
    .page_i(s_reg.addr[`EBR_PAGE_HI:`EBR_PAGE_LO]),
    .external_access_strobe_n_i(s_reg.external_access_strobe_n),
    .page_sel_n_o(page_sel_n_o)
  );

  // Synchronised pin levels only; never the first stage
  assign ext_ready = ~s_reg.rdy_s2; // RL14
  assign floating = ~s_reg.flt_s2;
  assign req_bank = req_addr_i[`EBR_BANK_HI:`EBR_BANK_LO];

  // Ready source mux
  always_comb begin
    case (s_reg.sel) // RL2
      EBR_SEL_EXT: comb_ready = ext_ready;
      EBR_SEL_CNT: comb_ready = int_ready;
      EBR_SEL_AND: comb_ready = ext_ready | int_ready; // RL4
      EBR_SEL_OR: comb_ready = ext_ready & int_ready; // RL5 RL6
      default: comb_ready = int_ready;
    endcase
  end

  // No new access while pins are floated
  assign req_ready_o = (s_reg.st == EBR_IDLE) & ~floating;
  assign start = req_valid_i & req_ready_o;
  assign bank_change = s_reg.bank_valid & (req_bank != s_reg.last_bank);

  always_comb begin
    busctl_view = '0;
    busctl_view[`EBR_WCNT_HI:`EBR_WCNT_LO] = s_reg.wcnt;
    busctl_view[`EBR_SEL_HI:`EBR_SEL_LO] = s_reg.sel;
    busctl_view[`EBR_BCMP_BIT] = s_reg.bcmp;
  end

  always_comb begin
    status_view = '0;
    status_view[`EBR_STS_BUSY_BIT] = (s_reg.st != EBR_IDLE);
    status_view[`EBR_STS_WPEND_BIT] = (s_reg.st != EBR_IDLE) & s_reg.is_wr;
    status_view[`EBR_STS_RDY_BIT] = ext_ready;
    status_view[`EBR_STS_FLOAT_BIT] = floating;
    status_view[`EBR_STS_NULL_BIT] = (s_reg.st == EBR_NULL);
  end

  always_comb begin
    s_next = s_reg;
    cnt_load = 1'b0;
    s_next.rd_valid = 1'b0;

    // Two-flop synchronisers for pin inputs
    s_next.rdy_s1 = ext_ready_n_i;
    s_next.rdy_s2 = s_reg.rdy_s1;
    s_next.flt_s1 = pin_float_control_n_i;
    s_next.flt_s2 = s_reg.flt_s1;
    s_next.din_s1 = ext_data_i;
    s_next.din_s2 = s_reg.din_s1;

    // Register write: one control register for all timing
    if (reg_we_i && (reg_addr_i == `EBR_REG_BUSCTL)) begin
      s_next.wcnt = reg_wdata_i[`EBR_WCNT_HI:`EBR_WCNT_LO]; // RL12
      s_next.sel = ebr_rdy_sel_t'(reg_wdata_i[`EBR_SEL_HI:`EBR_SEL_LO]); // RL2
      s_next.bcmp = reg_wdata_i[`EBR_BCMP_BIT]; // RL7
    end

    // Register read, data valid in the next cycle only
    s_next.reg_rdata = '0;
    if (reg_re_i) begin
      case (reg_addr_i)
        `EBR_REG_BUSCTL: s_next.reg_rdata = busctl_view;
        `EBR_REG_STATUS: s_next.reg_rdata = status_view;
        default: s_next.reg_rdata = '0;
      endcase
    end

    case (s_reg.st)
      EBR_IDLE: begin
        if (start) begin
          // Latch is the posting buffer; core is released at once
          s_next.addr = req_addr_i; // RL8
          s_next.wdata = req_wdata_i; // RL8
          s_next.is_wr = req_we_i;
          // Only reads pay the idle cycle on a bank change
          if (!req_we_i && s_reg.bcmp && bank_change) begin
            s_next.st = EBR_NULL; // RL7
          end else begin
            s_next.st = EBR_ACC;
            s_next.external_access_strobe_n = 1'b0;
            s_next.oe_n = ~req_we_i;
            cnt_load = 1'b1; // RL13
          end
          s_next.last_bank = req_bank;
          s_next.bank_valid = 1'b1;
        end
      end
      EBR_NULL: begin
        s_next.st = EBR_ACC; // RL7
        s_next.external_access_strobe_n = 1'b0;
        cnt_load = 1'b1; // RL13
      end
      EBR_ACC: begin
        // Decision on the synchronised level at this edge
        if (comb_ready) begin // RL1
          s_next.st = EBR_IDLE;
          s_next.external_access_strobe_n = 1'b1;
          s_next.oe_n = 1'b1;
          if (!s_reg.is_wr) begin
            s_next.rdata = s_reg.din_s2;
            s_next.rd_valid = 1'b1;
          end
        end
      end
      default: begin
        s_next.st = EBR_IDLE;
        s_next.external_access_strobe_n = 1'b1;
        s_next.oe_n = 1'b1;
      end
    endcase

    // Keeper follows whoever drove the bus last
    if (!s_reg.oe_n) begin
      s_next.keep_val = s_reg.wdata; // RL9
    end else if ((s_reg.st == EBR_ACC) && comb_ready && !s_reg.is_wr) begin
      s_next.keep_val = s_reg.din_s2; // RL9
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= EBR_IDLE;
      s_reg.wcnt <= `EBR_WCNT_W'(`EBR_BUSCTL_RST >> `EBR_WCNT_LO);
      s_reg.sel <= EBR_SEL_OR; // RL3
      s_reg.oe_n <= 1'b1;
      s_reg.external_access_strobe_n <= 1'b1;
      s_reg.rdy_s1 <= 1'b1;
      s_reg.rdy_s2 <= 1'b1;
      s_reg.flt_s1 <= 1'b1;
      s_reg.flt_s2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata_o = s_reg.reg_rdata;
  assign rd_data_o = s_reg.rdata;
  assign rd_valid_o = s_reg.rd_valid;
  assign ext_addr_o = s_reg.addr;
  assign ext_data_o = s_reg.wdata;
  // Float control overrides the data and keeper drive; address, strobe and page selects stay driven
  assign ext_data_oe_n_o = s_reg.oe_n | floating;
  assign ext_external_access_strobe_n_o = s_reg.external_access_strobe_n;
  assign ext_rw_o = ~s_reg.is_wr;
  assign keep_val_o = s_reg.keep_val;
  assign keep_en_o = ~floating; // RL9

endmodule // ebr_bus_ctrl

// *** ebr_cfg.svh ***
// Constants for the external bus ready and wait-state block.
// Assumes a 32-bit register port with a 4-bit byte address.
`ifndef EBR_CFG_SVH
`define EBR_CFG_SVH

// Register byte offsets
`define EBR_REG_BUSCTL 4'h0
`define EBR_REG_STATUS 4'h4
`define EBR_REG_AW 4

// Bus control register fields
`define EBR_SEL_HI 4
`define EBR_SEL_LO 3
`define EBR_WCNT_HI 7
`define EBR_WCNT_LO 5
`define EBR_BCMP_BIT 8
`define EBR_BUSCTL_RST 32'h000000F8
`define EBR_WCNT_W 3

// Status register fields
`define EBR_STS_BUSY_BIT 0
`define EBR_STS_WPEND_BIT 1
`define EBR_STS_RDY_BIT 2
`define EBR_STS_FLOAT_BIT 3
`define EBR_STS_NULL_BIT 4

// External bus geometry
`define EBR_AW 24
`define EBR_DW 32
`define EBR_BANK_HI 23
`define EBR_BANK_LO 16
`define EBR_PAGE_HI 23
`define EBR_PAGE_LO 22
`define EBR_NPAGE 4

`endif

// *** ebr_pkg.sv ***
// Types for the external bus ready and wait-state block.
// Assumes ebr_cfg.svh is on the include path.
`include "ebr_cfg.svh"

package ebr_pkg;

  typedef enum logic [1:0] {
    EBR_IDLE = 2'b00,
    EBR_NULL = 2'b01,
    EBR_ACC = 2'b11
  } ebr_state_t;

  typedef enum logic [1:0] {
    EBR_SEL_EXT = 2'b00,
    EBR_SEL_CNT = 2'b01,
    EBR_SEL_AND = 2'b10,
    EBR_SEL_OR = 2'b11
  } ebr_rdy_sel_t;

  typedef struct packed {
    ebr_state_t st;
    logic [`EBR_WCNT_W-1:0] wcnt;
    ebr_rdy_sel_t sel;
    logic bcmp;
    logic [`EBR_AW-1:0] addr;
    logic [`EBR_DW-1:0] wdata;
    logic is_wr;
    logic oe_n;
    logic external_access_strobe_n;
    logic [`EBR_BANK_HI-`EBR_BANK_LO:0] last_bank;
    logic bank_valid;
    logic [`EBR_DW-1:0] rdata;
    logic rd_valid;
    logic [`EBR_DW-1:0] reg_rdata;
    logic rdy_s1;
    logic rdy_s2;
    logic flt_s1;
    logic flt_s2;
    logic [`EBR_DW-1:0] din_s1;
    logic [`EBR_DW-1:0] din_s2;
    logic [`EBR_DW-1:0] keep_val;
  } ebr_ctrl_state_t;

  typedef struct packed {
    logic [`EBR_WCNT_W-1:0] cnt;
  } ebr_wcnt_state_t;

endpackage

// *** ebr_wait_counter.sv ***
// Internal wait-state counter.
// Assumes load_i pulses on the edge that starts the strobe phase.
`include "ebr_cfg.svh"

module ebr_wait_counter (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [`EBR_WCNT_W-1:0] load_val_i,
  output logic int_ready_o
);
  import ebr_pkg::*;

  ebr_wcnt_state_t s_reg;
  ebr_wcnt_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (load_i) begin
      s_next.cnt = load_val_i; // RL13
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - `EBR_WCNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Ready once the loaded count has run down
  assign int_ready_o = (s_reg.cnt == '0); // RL13

endmodule // ebr_wait_counter

// *** ebr_page_decode.sv ***
// Predecoded page selects from the top address bits and the strobe.
// Assumes registered address and strobe inputs, so outputs are glitch free.
`include "ebr_cfg.svh"

module ebr_page_decode (
  input wire logic [`EBR_PAGE_HI-`EBR_PAGE_LO:0] page_i,
  input wire logic external_access_strobe_n_i,
  output logic [`EBR_NPAGE-1:0] page_sel_n_o
);
  import ebr_pkg::*;

  genvar g;
  generate
    for (g = 0; g < `EBR_NPAGE; g = g + 1) begin : g_page
      // One quarter of the space each, only while strobing
      assign page_sel_n_o[g] = external_access_strobe_n_i | (page_i != 2'(g)); // RL11
    end
  endgenerate

endmodule // ebr_page_decode

// *** ebr_bus_ctrl_assertions.sv ***
// Bound checker for ebr_bus_ctrl pin and register-port timing.
// Assumes bus control is only rewritten while the bus is idle.
module ebr_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic req_valid_i,
  input wire logic req_we_i,
  input wire logic [23:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic req_ready_o,
  input wire logic rd_valid_o,
  input wire logic [23:0] ext_addr_o,
  input wire logic [31:0] ext_data_o,
  input wire logic ext_data_oe_n_o,
  input wire logic ext_external_access_strobe_n_o,
  input wire logic ext_rw_o,
  input wire logic ext_ready_n_i,
  input wire logic pin_float_control_n_i,
  input wire logic [3:0] page_sel_n_o,
  input wire logic keep_en_o
);
  logic [2:0] wc;
  logic [1:0] sel;
  logic bc;
  logic [7:0] lo;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Shadow of bus control, so strobe length can be judged
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      {bc, wc, sel} <= 6'h1F;
      lo <= 8'h00;
    end else begin
      if (reg_we_i && reg_addr_i == 4'h0) {bc, wc, sel} <= reg_wdata_i[8:3];
      lo <= ext_external_access_strobe_n_o ? 8'h00 : lo + 8'h01;
    end
  end
  a_page_idle: assert property (ext_external_access_strobe_n_o |-> page_sel_n_o == 4'hF)
    else $error("page select without strobe");
  a_page_decode: assert property (!ext_external_access_strobe_n_o |->
    page_sel_n_o == ~(4'h1 << ext_addr_o[23:22])) else $error("page select wrong");
  a_float_off: assert property ((!pin_float_control_n_i) [*4] |=>
    ext_data_oe_n_o && !keep_en_o && !req_ready_o) else $error("float not honoured");
  a_keep_on: assert property (pin_float_control_n_i [*4] |=> keep_en_o)
    else $error("keeper dropped");
  a_write_post: assert property (req_valid_i && req_ready_o && req_we_i |=>
    !ext_external_access_strobe_n_o && !ext_rw_o && !ext_data_oe_n_o && ext_data_o == $past(req_wdata_i)
    && ext_addr_o == $past(req_addr_i)) else $error("posted write not on bus");
  a_read_start: assert property (req_valid_i && req_ready_o && !req_we_i && !bc |=>
    !ext_external_access_strobe_n_o && ext_rw_o) else $error("read start delayed");
  a_wait_min: assert property ($rose(ext_external_access_strobe_n_o) && sel[0] |-> lo > 8'(wc)
    && (sel[1] || lo == 8'(wc) + 8'h01)) else $error("strobe length off the count");
  a_ready_hold: assert property ((!ext_external_access_strobe_n_o && ext_ready_n_i && sel != 2'b01
    && sel != 2'b10) [*4] |=> !ext_external_access_strobe_n_o) else $error("access ended while not ready");
  a_reg_rd_once: assert property (!reg_re_i |=> reg_rdata_o == 32'h0)
    else $error("register data outside read slot");
  a_done_pulse: assert property (rd_valid_o |-> ext_external_access_strobe_n_o && !$past(ext_external_access_strobe_n_o)
    && ext_rw_o ##1 !rd_valid_o) else $error("read completion misplaced");
endmodule // ebr_chk

bind ebr_bus_ctrl ebr_chk u_chk (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
  .reg_re_i, .reg_rdata_o, .req_valid_i, .req_we_i, .req_addr_i, .req_wdata_i,
  .req_ready_o, .rd_valid_o, .ext_addr_o, .ext_data_o, .ext_data_oe_n_o, .ext_external_access_strobe_n_o,
  .ext_rw_o, .ext_ready_n_i, .pin_float_control_n_i, .page_sel_n_o, .keep_en_o);

// *** ebr_ext_dev.sv ***
// External memory with a settable ready stall.
// Assumes the bench resolves the shared data wire.
module ebr_ext_dev (
  input wire logic mclk_i,
  input wire logic [23:0] addr_i,
  input wire logic [31:0] data_i,
  input wire logic external_access_strobe_n_i,
  input wire logic rw_i,
  input wire logic [3:0] stall_i,
  output logic [31:0] data_o,
  output logic drive_o,
  output logic ready_n_o
);
  logic [31:0] mem [16];
  logic [3:0] cnt;
  always_ff @(posedge mclk_i) begin
    cnt <= external_access_strobe_n_i ? 4'h0 : cnt + {3'h0, cnt != stall_i};
    if (!external_access_strobe_n_i && !rw_i) mem[addr_i[3:0]] <= data_i;
  end
  assign drive_o = !external_access_strobe_n_i && rw_i;
  assign data_o = mem[addr_i[3:0]];
  // Stalling: not ready outside strobes, so no stale ready leaks in
  assign ready_n_o = stall_i != 4'h0 && (external_access_strobe_n_i || cnt != stall_i);
endmodule // ebr_ext_dev

// *** ebr_bus_ctrl_tb_top.sv ***
// Self-checking bench for ebr_bus_ctrl against an external memory model.
// Assumes the bound checker is compiled with it.
module ebr_bus_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, rwe = 1'b0, rre = 1'b0, rv = 1'b0, rwr = 1'b0, flt_n = 1'b1;
  logic [3:0] ra = 4'h0, pg, stall = 4'h0;
  logic [31:0] rwd = 32'h0, qd = 32'h0, rrd, rdd, xd, bus_w, pd, last_w, kv;
  logic [23:0] qa = 24'h0, xa;
  logic rdy, rdv, oe_n, external_access_strobe_n, rw, rdy_n, drv, ke;
  int miscompares = 0, n_checks = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  ebr_bus_ctrl uut (.mclk_i(clk), .rst_i(rst), .reg_addr_i(ra), .reg_wdata_i(rwd),
    .reg_we_i(rwe), .reg_re_i(rre), .reg_rdata_o(rrd), .req_valid_i(rv), .req_we_i(rwr),
    .req_addr_i(qa), .req_wdata_i(qd), .req_ready_o(rdy), .rd_data_o(rdd),
    .rd_valid_o(rdv), .ext_addr_o(xa), .ext_data_o(xd), .ext_data_oe_n_o(oe_n),
    .ext_data_i(bus_w), .ext_external_access_strobe_n_o(external_access_strobe_n), .ext_rw_o(rw), .ext_ready_n_i(rdy_n),
    .pin_float_control_n_i(flt_n), .page_sel_n_o(pg), .keep_val_o(kv), .keep_en_o(ke));
  ebr_ext_dev dev (.mclk_i(clk), .addr_i(xa), .data_i(bus_w), .external_access_strobe_n_i(external_access_strobe_n),
    .rw_i(rw), .stall_i(stall), .data_o(pd), .drive_o(drv), .ready_n_o(rdy_n));
  // Undriven, unkept wire toggles rather than holding a lucky value
  assign bus_w = !oe_n ? xd : drv ? pd : ke ? kv : ~last_w;
  always @(posedge clk) last_w <= bus_w;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwe <= 1'b1;
    @(posedge clk);
    rwe <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, string nm);
    @(posedge clk);
    ra <= a;
    rre <= 1'b1;
    @(posedge clk);
    rre <= 1'b0;
    @(negedge clk);
    chk(nm, rrd, e);
  endtask
  // Read latency counted in cycles from the edge that takes the request
  task automatic acc(logic we, logic [23:0] a, logic [31:0] d, output int lat);
    @(posedge clk);
    rv <= 1'b1;
    rwr <= we;
    qa <= a;
    qd <= d;
    do @(negedge clk); while (rdy !== 1'b1);
    @(posedge clk);
    rv <= 1'b0;
    lat = 0;
    if (!we) begin
      do begin
        @(negedge clk);
        lat++;
      end while (rdv !== 1'b1 && lat < 60);
    end
  endtask
  function automatic logic ok_lat(logic [1:0] s, logic [2:0] w, logic [3:0] st, int lat);
    if (st == 4'h0)
      return lat == (s[0] ? w + 2 : 2);
    if (s == 2'b01 || s == 2'b10)
      return lat == w + 2;
    return lat > st + 1 && lat < st + 8;
  endfunction
  initial begin
    int lat;
    logic [23:0] a;
    logic [31:0] d;
    logic [2:0] w;
    void'($urandom(26));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 32'h000000F8, "busctl reset");
    rd(4'hC, 32'h00000000, "unmapped");
    wr(4'h4, 32'hFFFFFFFF);
    rd(4'h4, 32'h00000004, "status");
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      // Top address bit fed back as the slow-device ready
      a = {i[3], 23'($urandom)};
      stall <= a[23] ? 4'hC : 4'h0;
      w = 3'(2 + $urandom % 6);
      wr(4'h0, {23'h0, 1'b0, w, i[1:0], 3'h0});
      d = $urandom;
      acc(1'b1, a, d, lat);
      do @(negedge clk); while (rdy !== 1'b1);
      @(negedge clk);
      chk("keeper value", kv, d);
      acc(1'b0, a, 32'h0, lat);
      if (stall != 4'h0 || i[0]) chk("read data", rdd, d);
      chk("latency", 32'(ok_lat(i[1:0], w, stall, lat)), 32'h1);
    end
    $display("ready mode test done");
    stall <= 4'h0;
    wr(4'h0, 32'h00000168);
    acc(1'b0, 24'h120000, 32'h0, lat);
    acc(1'b0, 24'h340000, 32'h0, lat);
    chk("bank change read", 32'(lat), 32'h6);
    acc(1'b0, 24'h34FFF0, 32'h0, lat);
    chk("same bank read", 32'(lat), 32'h5);
    acc(1'b1, 24'h560000, 32'h5A5A5A5A, lat);
    acc(1'b0, 24'h560000, 32'h0, lat);
    chk("read after write", 32'(lat), 32'h5);
    chk("posted data", rdd, 32'h5A5A5A5A);
    $display("bank test done");
    @(posedge clk);
    flt_n <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("floated", 32'({ke, rdy, oe_n}), 32'h1);
    @(posedge clk);
    flt_n <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("released", 32'({ke, rdy, oe_n}), 32'h7);
    $display("float test done");
    close_out();
  end
endmodule // ebr_bus_ctrl_tb_top
